// >>> hdl/ccdc_msg.sv
// channel-change response and device-class request sequencer with APB registers
// assumes request/reply decode and message framing are done by the MAC around it
module ccdc_msg #(
   parameter int unsigned CYC_PER_MS = ccdc_pkg::CYC_PER_MS
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // downstream timestamp
   input  wire logic [31:0] ts_now,
   // decoded channel_change_request
   input  wire logic        ccq_valid,
   input  wire logic [15:0] ccq_tid,
   input  wire logic        ccq_same,
   input  wire logic        ccq_reinit,
   // channel_change_response fields
   output logic             ccr_valid,
   input  wire logic        ccr_ready,
   output logic [15:0]      ccr_tid,
   output logic [7:0]       ccr_code,
   output logic             ccr_keyseq,
   output logic             ccr_hmac_last,
   output logic [15:0]      ccr_jlen_hdr,
   output logic [31:0]      ccr_jlen,
   output logic [15:0]      ccr_jst_hdr,
   output logic [31:0]      ccr_jstart,
   output logic [31:0]      ccr_jacc,
   // tuner
   output logic             tune_go,
   input  wire logic        tune_done,
   // ranging and device_class_request
   input  wire logic        rng_done,
   input  wire logic [15:0] sid_tmp,
   output logic             dq_valid,
   input  wire logic        dq_ready,
   output logic [15:0]      dq_sid,
   output logic [31:0]      dq_mask,
   // device_class_reply
   input  wire logic        dr_valid,
   input  wire logic [7:0]  dr_code,
   input  wire logic [15:0] dr_sid,
   // initialisation control
   output logic             init_hold,
   output logic             reg_go,
   output logic             rescan
);
   ccdc_pkg::ccdc_cc_state_t cc_state;
   ccdc_pkg::ccdc_dc_state_t dc_state;
   logic [4:0]  ctrl_reg;
   logic [31:0] jlen_reg;
   logic [31:0] jlead_reg;
   logic [31:0] jacc_reg;
   logic [23:0] dcfg_reg;
   logic [15:0] drop_reg;
   logic        reinit_reg;
   logic [7:0]  retry_reg;
   logic [7:0]  dcode_reg;
   logic        tmr_start;
   logic        tmr_exp;
   logic [31:0] rd_next;
   logic        err_next;
   logic        wr_en;
   logic        dr_hit;
   logic        cc_take;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait-free access phase, read data fetched in setup
   assign wr_en = psel && penable && pready && pwrite;

   always_comb begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      if (paddr == ccdc_pkg::A_CTRL) begin
         rd_next = {27'h0, ctrl_reg};
      end else if (paddr == ccdc_pkg::A_JLEN) begin
         rd_next = jlen_reg;
      end else if (paddr == ccdc_pkg::A_JLEAD) begin
         rd_next = jlead_reg;
      end else if (paddr == ccdc_pkg::A_JACC) begin
         rd_next = jacc_reg;
      end else if (paddr == ccdc_pkg::A_DCFG) begin
         rd_next = {8'h00, dcfg_reg};
      end else if (paddr == ccdc_pkg::A_STAT) begin
         rd_next[ccdc_pkg::ST_CC +: 4]    = cc_state;
         rd_next[ccdc_pkg::ST_DCI +: 5]   = dc_state;
         rd_next[ccdc_pkg::ST_RETRY +: 8] = retry_reg;
         rd_next[ccdc_pkg::ST_CODE +: 8]  = dcode_reg;
      end else if (paddr == ccdc_pkg::A_DROP) begin
         rd_next = {16'h0000, drop_reg};
      end else begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         prdata  <= (psel && !penable && !pwrite) ? rd_next : 32'h0000_0000;
         pslverr <= psel && !penable && err_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= ccdc_pkg::CTRL_RST;
         jlen_reg  <= ccdc_pkg::JREG_RST;
         jlead_reg <= ccdc_pkg::JREG_RST;
         jacc_reg  <= ccdc_pkg::JREG_RST;
         dcfg_reg  <= ccdc_pkg::DCFG_RST;
      end else if (wr_en) begin
         if (paddr == ccdc_pkg::A_CTRL) begin
            ctrl_reg <= pwdata[4:0];
         end else if (paddr == ccdc_pkg::A_JLEN) begin
            jlen_reg <= pwdata;
         end else if (paddr == ccdc_pkg::A_JLEAD) begin
            jlead_reg <= pwdata;
         end else if (paddr == ccdc_pkg::A_JACC) begin
            jacc_reg <= pwdata;
         end else if (paddr == ccdc_pkg::A_DCFG) begin
            dcfg_reg <= pwdata[23:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel change sequencing
   assign cc_take = ccq_valid && (cc_state == ccdc_pkg::CC_IDLE);

   // start stamp straight from the capture flop
   ccdc_jmp u_jmp (
      .pclk     (pclk),
      .presetn  (presetn),
      .ts_now   (ts_now),
      .lead     (jlead_reg),
      .capture  (cc_take),
      .start_ts (ccr_jstart)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_state   <= ccdc_pkg::CC_IDLE;
         ccr_valid  <= 1'b0;
         ccr_tid    <= 16'h0000;
         ccr_code   <= 8'h00;
         reinit_reg <= 1'b0;
         tune_go    <= 1'b0;
      end else begin
         tune_go <= 1'b0;
         case (cc_state)
            ccdc_pkg::CC_IDLE: begin
               if (ccq_valid) begin
                  ccr_valid  <= 1'b1;
                  ccr_tid    <= ccq_tid;
                  reinit_reg <= ccq_reinit;
                  if (ccq_same) begin
                     ccr_code <= ccdc_pkg::CC_ALREADY;
                     cc_state <= ccdc_pkg::CC_NEW;
                  end else begin
                     ccr_code <= ccdc_pkg::CC_DEPART;
                     cc_state <= ccdc_pkg::CC_OLD;
                  end
               end
            end
            ccdc_pkg::CC_OLD: begin
               if (ccr_ready) begin
                  ccr_valid <= 1'b0;
                  tune_go   <= 1'b1;
                  cc_state  <= ccdc_pkg::CC_TUNE;
               end
            end
            ccdc_pkg::CC_TUNE: begin
               if (tune_done) begin
                  ccr_valid <= !reinit_reg;
                  ccr_code  <= ccdc_pkg::CC_ARRIVE;
                  cc_state  <= reinit_reg ? ccdc_pkg::CC_IDLE : ccdc_pkg::CC_NEW;
               end
            end
            ccdc_pkg::CC_NEW: begin
               if (ccr_ready) begin
                  ccr_valid <= 1'b0;
                  cc_state  <= ccdc_pkg::CC_IDLE;
               end
            end
            default: begin
               cc_state <= ccdc_pkg::CC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_reg <= 16'h0000;
      end else if (ccq_valid && (cc_state != ccdc_pkg::CC_IDLE)) begin
         drop_reg <= drop_reg + 16'h0001;
      end
   end

   // jump elements ride only on the departing response; settings frozen per request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccr_keyseq    <= 1'b0;
         ccr_hmac_last <= 1'b0;
         ccr_jlen_hdr  <= 16'h0000;
         ccr_jlen      <= 32'h0000_0000;
         ccr_jst_hdr   <= 16'h0000;
         ccr_jacc      <= 32'h0000_0000;
      end else if (cc_take) begin
         ccr_keyseq    <= ctrl_reg[ccdc_pkg::B_PRIV];
         ccr_hmac_last <= ctrl_reg[ccdc_pkg::B_PRIV];
         ccr_jlen_hdr  <= (ctrl_reg[ccdc_pkg::B_JUMP] && !ccq_same) ? ccdc_pkg::JT_LEN_HDR : 16'h0000;
         ccr_jlen      <= jlen_reg;
         ccr_jst_hdr   <= (ctrl_reg[ccdc_pkg::B_JUMP] && ctrl_reg[ccdc_pkg::B_START] && !ccq_same) ?
                          ccdc_pkg::JT_START_HDR : 16'h0000;
         ccr_jacc      <= jacc_reg;
      end else if (cc_state == ccdc_pkg::CC_TUNE) begin
         ccr_jlen_hdr <= 16'h0000;
         ccr_jst_hdr  <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // device class handshake
   assign dr_hit = dr_valid && (dc_state == ccdc_pkg::D_WAIT) && (dr_sid == dq_sid);

   ccdc_tmr #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (tmr_start),
      .run      (dc_state == ccdc_pkg::D_WAIT),
      .limit_ms (dcfg_reg[15:0]),
      .expired  (tmr_exp)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dc_state  <= ccdc_pkg::D_IDLE;
         dq_valid  <= 1'b0;
         dq_sid    <= 16'h0000;
         dq_mask   <= 32'h0000_0000;
         retry_reg <= 8'h00;
         dcode_reg <= 8'h00;
         tmr_start <= 1'b0;
         init_hold <= 1'b0;
         reg_go    <= 1'b0;
         rescan    <= 1'b0;
      end else begin
         tmr_start <= 1'b0;
         rescan    <= 1'b0;
         if (rng_done && dc_state != ccdc_pkg::D_SEND && dc_state != ccdc_pkg::D_WAIT) begin
            // request right after ranging, hold init
            // identifier plus mask, upper bits zero
            dq_sid    <= sid_tmp;
            dq_mask   <= {31'h0, ctrl_reg[ccdc_pkg::B_CPE_CONTROLLED_MODEM]};
            retry_reg <= 8'h00;
            dq_valid  <= ctrl_reg[ccdc_pkg::B_DCI];
            init_hold <= ctrl_reg[ccdc_pkg::B_DCI];
            reg_go    <= !ctrl_reg[ccdc_pkg::B_DCI];
            dc_state  <= ctrl_reg[ccdc_pkg::B_DCI] ? ccdc_pkg::D_SEND : ccdc_pkg::D_DONE;
         end else begin
            case (dc_state)
               ccdc_pkg::D_SEND: begin
                  if (dq_ready) begin
                     dq_valid  <= 1'b0;
                     tmr_start <= 1'b1;
                     dc_state  <= ccdc_pkg::D_WAIT;
                  end
               end
               ccdc_pkg::D_WAIT: begin
                  if (dr_hit && dr_code == ccdc_pkg::DC_OK) begin
                     dcode_reg <= dr_code;
                     init_hold <= 1'b0;
                     reg_go    <= 1'b1;
                     dc_state  <= ccdc_pkg::D_DONE;
                  end else if (dr_hit && dr_code == ccdc_pkg::DC_TEMP) begin
                     dcode_reg <= dr_code;
                     retry_reg <= 8'h00;
                     dq_valid  <= 1'b1;
                     dc_state  <= ccdc_pkg::D_SEND;
                  end else if (dr_hit && dr_code == ccdc_pkg::DC_PERM) begin
                     dcode_reg <= dr_code;
                     init_hold <= 1'b0;
                     rescan    <= 1'b1;
                     dc_state  <= ccdc_pkg::D_ABORT;
                  end else if (tmr_exp) begin
                     if (retry_reg >= dcfg_reg[23:16]) begin
                        init_hold <= 1'b0;
                        rescan    <= 1'b1;
                        dc_state  <= ccdc_pkg::D_ABORT;
                     end else begin
                        retry_reg <= retry_reg + 8'h01;
                        dq_valid  <= 1'b1;
                        dc_state  <= ccdc_pkg::D_SEND;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_rsp_before_tune: assert property (
      tune_go |-> $past(ccr_valid) && $past(ccr_ready) && $past(cc_state) == ccdc_pkg::CC_OLD)
      else $error("retune without old-channel response");
   chk_tid_copied: assert property (
      cc_take |=> ccr_valid && ccr_tid == $past(ccq_tid))
      else $error("response id not copied");
   chk_same_chan: assert property (
      cc_take && ccq_same |=> ccr_code == ccdc_pkg::CC_ALREADY && cc_state == ccdc_pkg::CC_NEW)
      else $error("already-there reply wrong");
   chk_busy_drop: assert property (
      ccq_valid && cc_state != ccdc_pkg::CC_IDLE |=> drop_reg == $past(drop_reg) + 16'h0001)
      else $error("dropped request not counted");
   chk_reinit_quiet: assert property (
      cc_state == ccdc_pkg::CC_TUNE && tune_done && reinit_reg |=> !ccr_valid && cc_state == ccdc_pkg::CC_IDLE)
      else $error("response sent after reinit");
   chk_arrive_sent: assert property (
      cc_state == ccdc_pkg::CC_TUNE && tune_done && !reinit_reg |=> ccr_valid && ccr_code == ccdc_pkg::CC_ARRIVE)
      else $error("no arrive response");
   chk_priv_attrs: assert property (
      cc_take |=> ccr_keyseq == $past(ctrl_reg[0]) && ccr_hmac_last == ccr_keyseq)
      else $error("privacy attributes wrong");
   chk_jump_hdr: assert property (
      ccr_valid && ccr_jlen_hdr != 16'h0000 |-> ccr_jlen_hdr == ccdc_pkg::JT_LEN_HDR && ccr_code == ccdc_pkg::CC_DEPART)
      else $error("bad jump length header");
   chk_dci_mask: assert property (
      dq_valid |-> dq_mask[31:1] == 31'h0 && init_hold)
      else $error("device class mask reserved bits set");
   chk_temp_resend: assert property (
      dr_hit && dr_code == ccdc_pkg::DC_TEMP && !rng_done |=> dq_valid && retry_reg == 8'h00)
      else $error("temporary reject not resent");
   chk_perm_rescan: assert property (
      dr_hit && dr_code == ccdc_pkg::DC_PERM && !rng_done |=> rescan && !reg_go ##1 !rescan)
      else $error("permanent reject not rescanned");
   chk_ok_go: assert property (
      dr_hit && dr_code == ccdc_pkg::DC_OK && !rng_done |=> reg_go && !init_hold)
      else $error("success did not release init");
endmodule // ccdc_msg

// >>> include/ccdc_pkg.sv
// constants, register map and state types of the channel-change / device-class messenger
// assumes one 10 MHz clock and an APB master for software access
package ccdc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  A_CTRL = 8'h00;
   localparam logic [7:0]  A_JLEN = 8'h04;
   localparam logic [7:0]  A_JLEAD = 8'h08;
   localparam logic [7:0]  A_JACC = 8'h0c;
   localparam logic [7:0]  A_DCFG = 8'h10;
   localparam logic [7:0]  A_STAT = 8'h14;
   localparam logic [7:0]  A_DROP = 8'h18;
   localparam int          B_PRIV = 0;
   localparam int          B_DCI = 1;
   localparam int          B_CPE_CONTROLLED_MODEM = 2;
   localparam int          B_JUMP = 3;
   localparam int          B_START = 4;
   localparam logic [4:0]  CTRL_RST = 5'h18;
   localparam logic [23:0] DCFG_RST = 24'h03_0064;
   localparam logic [31:0] JREG_RST = 32'h0000_0000;
   localparam int          ST_CC = 0;
   localparam int          ST_DCI = 4;
   localparam int          ST_RETRY = 16;
   localparam int          ST_CODE = 24;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  CC_ARRIVE = 8'h01;
   localparam logic [7:0]  CC_DEPART = 8'h02;
   localparam logic [7:0]  CC_ALREADY = 8'h03;
   localparam logic [7:0]  DC_OK = 8'h00;
   localparam logic [7:0]  DC_TEMP = 8'h03;
   localparam logic [7:0]  DC_PERM = 8'h04;
   localparam logic [15:0] JT_LEN_HDR = 16'h0104;
   localparam logic [15:0] JT_START_HDR = 16'h0208;
   ////////////////////////////////////////////////////////////////////////////
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          MS_NS = 1000000;
   localparam int          CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int          TS_HZ = 10240000;
   typedef enum logic [3:0] {
      CC_IDLE = 4'b0001, CC_OLD = 4'b0010, CC_TUNE = 4'b0100, CC_NEW = 4'b1000
   } ccdc_cc_state_t;
   typedef enum logic [4:0] {
      D_IDLE = 5'b00001, D_SEND = 5'b00010, D_WAIT = 5'b00100, D_DONE = 5'b01000, D_ABORT = 5'b10000
   } ccdc_dc_state_t;
endpackage

// >>> hdl/ccdc_tmr.sv
// retry timer: millisecond tick divider and a millisecond counter
// assumes start is a one-cycle pulse and limit_ms is stable while running
module ccdc_tmr #(
   parameter int unsigned CYC_PER_MS = ccdc_pkg::CYC_PER_MS
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        start,
   input  wire logic        run,
   input  wire logic [15:0] limit_ms,
   // result
   output logic             expired
);
   localparam int DW = $clog2(CYC_PER_MS + 1);
   logic [DW-1:0] div_reg;
   logic          tick_reg;
   logic [15:0]   ms_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (start || !run) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (div_reg == DW'(CYC_PER_MS - 1)) begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // a zero limit behaves as one millisecond
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_reg  <= 16'h0000;
         expired <= 1'b0;
      end else if (start) begin
         ms_reg  <= 16'h0000;
         expired <= 1'b0;
      end else if (run && tick_reg && (ms_reg + 16'h0001 >= limit_ms)) begin
         ms_reg  <= 16'h0000;
         expired <= 1'b1;
      end else begin
         ms_reg  <= (run && tick_reg) ? ms_reg + 16'h0001 : ms_reg;
         expired <= 1'b0;
      end
   end
endmodule // ccdc_tmr

// >>> hdl/ccdc_jmp.sv
// start-of-jump stamp on the downstream timestamp base
// assumes ts_now is the running 32-bit timestamp count
module ccdc_jmp (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // inputs
   input  wire logic [31:0] ts_now,
   input  wire logic [31:0] lead,
   input  wire logic        capture,
   // result
   output logic [31:0]      start_ts
);
   // timestamp units
   // plain modulo add: a wrapped start is left to the head-end to interpret
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_ts <= 32'h0000_0000;
      end else if (capture) begin
         start_ts <= ts_now + lead;
      end
   end
endmodule // ccdc_jmp

// >>> bench/ccdc_headend.sv
// head-end and MAC model: takes responses, retunes, answers device-class requests
// assumes all outputs move only just after rising pclk
module ccdc_headend (
   // clock
   input  wire logic        pclk,
   // channel_change_response from the messenger
   input  wire logic        ccr_valid,
   input  wire logic [15:0] ccr_tid,
   input  wire logic [7:0]  ccr_code,
   input  wire logic        ccr_keyseq,
   input  wire logic [31:0] ccr_jlen,
   input  wire logic [31:0] ccr_jstart,
   input  wire logic [31:0] ccr_jacc,
   output logic             ccr_ready,
   // tuner
   input  wire logic        tune_go,
   output logic             tune_done,
   // device_class_request and reply
   input  wire logic        dq_valid,
   input  wire logic [15:0] dq_sid,
   input  wire logic [31:0] dq_mask,
   output logic             dq_ready,
   output logic             dr_valid,
   output logic [7:0]       dr_code,
   output logic [15:0]      dr_sid,
   // bench controls
   input  wire logic [7:0]  reply_code,
   input  wire logic [7:0]  lag,
   // what the head-end keeps
   output logic             ack_valid,
   output logic [15:0]      ack_tid,
   output logic             ack_priv,
   output logic [31:0]      win_lo,
   output logic [31:0]      win_hi,
   output logic [31:0]      dhcp_class
);
   int n_cc = 0, n_dq = 0, n_tn = 0, n_dr = 0;
   initial {ccr_ready, tune_done, dq_ready, dr_valid, dr_code, dr_sid} = '0;
   initial {ack_valid, ack_tid, ack_priv, win_lo, win_hi, dhcp_class} = '0;
   always @(posedge pclk) begin
      n_cc <= (ccr_valid && !ccr_ready) ? n_cc + 1 : 0;
      ccr_ready <= ccr_valid && !ccr_ready && n_cc >= lag;
      n_dq <= (dq_valid && !dq_ready) ? n_dq + 1 : 0;
      dq_ready <= dq_valid && !dq_ready && n_dq >= lag;
      n_tn <= tune_go ? lag : (n_tn > 0 ? n_tn - 1 : 0);
      tune_done <= n_tn == 1;
      // 8'hff stands for a head-end that never answers
      n_dr <= (dq_valid && dq_ready && reply_code != 8'hff) ? lag : (n_dr > 0 ? n_dr - 1 : 0);
      dr_valid <= n_dr == 1;
      dr_code <= n_dr == 1 ? reply_code : ~dr_code;
      // idle lines toggle so a stale value is never mistaken for a reply
      dr_sid <= n_dr == 1 ? dq_sid : ~dr_sid;
      ack_valid <= ccr_valid && ccr_ready && ccr_code == 8'h01;
      if (ccr_valid && ccr_ready && ccr_code == 8'h01) begin
         ack_tid  <= ccr_tid;
         ack_priv <= ccr_keyseq;
      end
      // modulo sums: a start below now lies one wrap ahead
      if (ccr_valid && ccr_ready && ccr_code == 8'h02) begin
         win_lo <= ccr_jstart - ccr_jacc;
         win_hi <= ccr_jstart + ccr_jacc + ccr_jlen;
      end
      // class kept for the relay option 82
      if (dq_valid && dq_ready) dhcp_class <= dq_mask;
   end
endmodule // ccdc_headend

// >>> bench/ccdc_msg_bench.sv
// self-checking bench of the channel-change and device-class messenger
// assumes ccdc_headend plays the far side; the bench is the apb master
module ccdc_msg_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic wr; logic [31:0] d, x; logic err;} ccdc_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, fin, ccq_valid, ccq_same;
   logic        ccq_reinit, ccr_valid, ccr_ready, ccr_keyseq, ccr_hmac_last, tune_go, tune_done, rng_done;
   logic        dq_valid, dq_ready, dr_valid, init_hold, reg_go, rescan, ack_valid, ack_priv;
   logic [7:0]  paddr, ccr_code, dr_code, reply_code;
   logic [15:0] ccq_tid, ccr_tid, ccr_jlen_hdr, ccr_jst_hdr, sid_tmp, dq_sid, dr_sid, ack_tid;
   logic [31:0] pwdata, prdata, ts_now, ccr_jlen, ccr_jstart, ccr_jacc, dq_mask, q, win_lo, win_hi, dhcp_class;
   int          num_errors = 0, comparisons = 0, nreq = 0;
   // address, write, data written, word read back, error
   ccdc_row_t   rows [9] = '{'{8'h00, 0, 32'h0, 32'h18, 0}, '{8'h04, 1, 32'h1234, 32'h1234, 0},
      '{8'h08, 1, 32'h10, 32'h10, 0}, '{8'h0c, 1, 32'h5, 32'h5, 0}, '{8'h10, 0, 32'h0, 32'h3_0064, 0},
      '{8'h10, 1, 32'h2_0002, 32'h2_0002, 0}, '{8'h14, 1, 32'hffff_ffff, 32'h11, 0},
      '{8'h1c, 1, 32'h5, 32'h0, 1}, '{8'h00, 1, 32'h1f, 32'h1f, 0}};
   assign fin = reg_go | rescan;
   ccdc_msg #(.CYC_PER_MS(4)) ccdc_msg_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ts_now, .ccq_valid, .ccq_tid, .ccq_same, .ccq_reinit, .ccr_valid, .ccr_ready, .ccr_tid,
      .ccr_code, .ccr_keyseq, .ccr_hmac_last, .ccr_jlen_hdr, .ccr_jlen, .ccr_jst_hdr, .ccr_jstart, .ccr_jacc,
      .tune_go, .tune_done, .rng_done, .sid_tmp, .dq_valid, .dq_ready, .dq_sid, .dq_mask, .dr_valid, .dr_code,
      .dr_sid, .init_hold, .reg_go, .rescan);
   ccdc_headend ccdc_headend_inst (.pclk, .ccr_valid, .ccr_tid, .ccr_code, .ccr_keyseq, .ccr_jlen, .ccr_jstart,
      .ccr_jacc, .ccr_ready, .tune_go, .tune_done, .dq_valid, .dq_sid, .dq_mask, .dq_ready, .dr_valid, .dr_code,
      .dr_sid, .reply_code, .lag(8'h02), .ack_valid, .ack_tid, .ack_priv, .win_lo, .win_hi, .dhcp_class);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (dq_valid && dq_ready) nreq <= nreq + 1;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t saw %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge pclk) penable <= 1'b1;
      while (pready !== 1'b1) @(posedge pclk);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic wait_for(ref logic s);
      for (int k = 0; k < 200 && s !== 1'b1; k++) @(posedge pclk);
      if (s !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t wait ran out", $time);
      end
   endtask
   task automatic cc_run(input logic same, input logic reinit, input logic [15:0] tid);
      {ccq_valid, ccq_same, ccq_reinit, ccq_tid, ts_now} <= {1'b1, same, reinit, tid, 32'hffff_fff8};
      @(posedge pclk) ccq_valid <= 1'b0;
      wait_for(ccr_valid);
      chk(ccr_code, same ? 32'h3 : 32'h2);
      chk(ccr_tid, tid);
      chk({ccr_keyseq, ccr_hmac_last}, 32'h3);
      if (!same) begin
         chk({ccr_jlen_hdr, ccr_jst_hdr}, 32'h0104_0208);
         chk(ccr_jlen, 32'h1234);
         chk(ccr_jacc, 32'h5);
         @(posedge pclk);
         chk(ccr_jstart, 32'h8);
         wait_for(tune_go);
         chk(ccr_valid, 1'b0);
         chk(win_lo, 32'h3);
         chk(win_hi, 32'h1241);
         ccq_valid <= 1'b1;
         @(posedge pclk) ccq_valid <= 1'b0;
         wait_for(tune_done);
         @(posedge pclk);
         chk(ccr_valid, !reinit);
         if (!reinit) begin
            chk({ccr_code, ccr_tid}, {8'h01, tid});
            wait_for(ack_valid);
            chk(ack_tid, tid);
            chk(ack_priv, 1'b1);
         end
      end
      repeat (10) @(posedge pclk);
      chk(ccr_valid, 1'b0);
   endtask
   task automatic dci_run(input logic [7:0] code, input int nexp);
      int n0;
      n0 = nreq;
      {reply_code, rng_done} <= {code, 1'b1};
      @(posedge pclk) rng_done <= 1'b0;
      @(posedge pclk);
      chk({dq_valid, init_hold}, 32'h3);
      chk(dq_sid, sid_tmp);
      chk(dq_mask, 32'h1);
      if (code == 8'h03) begin
         wait_for(dr_valid);
         @(posedge pclk) reply_code <= 8'h00;
      end
      wait_for(fin);
      chk(reg_go, code == 8'h00 || code == 8'h03);
      chk({init_hold, rescan}, {1'b0, code[2]});
      chk(nreq - n0, nexp);
      chk(dhcp_class, 32'h1);
   endtask
   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ts_now, ccq_valid, ccq_same, ccq_reinit, ccq_tid, rng_done} = '0;
      {presetn, sid_tmp, reply_code} = {1'b0, 16'h0123, 8'h00};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(q, rows[i].x);
         chk(e, rows[i].err);
      end
      cc_run(1'b0, 1'b0, 16'habcd);
      cc_run(1'b1, 1'b0, 16'h0001);
      cc_run(1'b0, 1'b1, 16'hffff);
      apb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h2);
      dci_run(8'h04, 1);
      dci_run(8'hff, 3);
      dci_run(8'h03, 2);
      dci_run(8'h00, 1);
      // reset in mid-run drops registration and settings
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({init_hold, dq_valid, reg_go, ccr_valid}, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h18);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      finish_test();
   end
endmodule // ccdc_msg_bench
